// >>> rtl/ppab_pkg.sv
// Summary of operation
// - General lines form ports; each bidirectional port has one direction bit per line.
// - Timer port has eight bidirectional pins tied to capture, compare, accumulator.
// - Timer direction bit 0 makes input, 1 makes output; clears on reset.
// - Pin 3 is fourth capture only with capture select set, else fifth compare.
// - Pin 3 as output with capture enabled: writes make rising edges that capture.
// - Writes to shared capture/compare register are ignored while it captures.
// - Pin 7 always feeds the pulse accumulator, whatever its direction or use.
// - Single-chip and bootstrap: upper address port is outputs, data resets to zero.
// - Expanded and test: upper port drives address 15..8, register leaves the map.
// - Single-chip and bootstrap: data-bus port leaves reset as high-impedance inputs.
// - Expanded and test: data-bus port carries data, direction by read/write, unmapped; its direction register stays readable and writable here.
// - Open-drain bit disables pull-ups; 0 drives low, 1 leaves pin floating.
// - Open-drain option acts only in single-chip or bootstrap mode.
// - Latches of pins floating at reset take the pin level seen on the first edge after reset.
// - Open-drain control is bit 6 of options register, reset 0, push-pull.
package ppab_pkg;
	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_TIMER_DATA = 14'h1000;
	localparam logic [13:0] IDX_TIMER_DIR = 14'h1001;
	localparam logic [13:0] IDX_UPPER_DATA = 14'h1004;
	localparam logic [13:0] IDX_DBUS_DATA = 14'h1006;
	localparam logic [13:0] IDX_DBUS_DIR = 14'h1007;
	localparam logic [13:0] IDX_OPTIONS_TWO = 14'h1038;
	localparam logic [13:0] IDX_PULSE_CTRL = 14'h1040;
	localparam logic [13:0] IDX_SHARED_CC = 14'h1041;
	// Field positions
	localparam int OPEN_DRAIN_BIT = 6;
	localparam int CAPTURE_SEL_BIT = 2;
	localparam int PIN_CAPTURE = 3;
	localparam int PIN_ACCUM = 7;
	// Values after reset
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] UPPER_RESET = 8'h00;
	localparam logic [7:0] OPTIONS_RESET = 8'h00;
	localparam logic [15:0] SHARED_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_EXPANDED = 2'b01,
		MODE_BOOT = 2'b10,
		MODE_TEST = 2'b11
	} ppab_mode_e;

	// Address phase held for the data phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [13:0] idx;
	} ppab_req_s;

	localparam ppab_req_s REQ_RESET = '{valid: 1'b0, write: 1'b0, idx: 14'h0000};
endpackage

// >>> rtl/ppab_port_logic.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module ppab_port_logic
	import ppab_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Operating mode
	input wire logic [1:0] op_mode,
	// Timer port pins
	input wire logic [7:0] ta_in,
	output logic [7:0] ta_out,
	output logic [7:0] ta_oe_n,
	// Timer compare outputs and pin feeds
	input wire logic [7:3] tmr_oc_en,
	input wire logic [7:3] tmr_oc_val,
	output logic [3:0] tmr_ic_pins,
	output logic tmr_pai,
	output logic [15:0] tmr_count,
	// Upper address port pins
	input wire logic [7:0] ext_addr_hi,
	output logic [7:0] pb_out,
	// Data-bus port pins
	input wire logic [7:0] pc_in,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe_n,
	output logic pc_pullup_en,
	// External bus data in expanded modes
	input wire logic ext_bus_rnw,
	input wire logic [7:0] ext_bus_wdata,
	output logic [7:0] ext_bus_rdata
);
	ppab_req_s req_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic [7:0] ta_latch_q;
	logic [7:0] ta_dir_q;
	logic [7:0] pb_latch_q;
	logic [7:0] pc_latch_q;
	logic [7:0] pc_dir_q;
	logic open_drain_q;
	logic capture_sel_q;
	logic [15:0] shared_cc_q;
	logic [15:0] count_q;
	logic pin3_prev_q;
	logic init_q;
	logic [7:0] ta_out_q;
	logic [7:0] ta_oe_n_q;
	logic [3:0] ic_pins_q;
	logic pai_q;
	logic [7:0] pb_out_q;
	logic [7:0] pc_out_q;
	logic [7:0] pc_oe_n_q;
	logic pullup_q;
	logic [7:0] bus_rdata_q;
	logic single_chip;
	logic take;
	logic wr_now;
	logic rd_now;
	logic cap_evt;
	logic [7:0] oc_drive;
	logic [7:0] oc_level;
	logic [31:0] rd_mux;

	// Single-chip and bootstrap share the port behaviour
	assign single_chip = (op_mode == MODE_SINGLE) || (op_mode == MODE_BOOT);
	assign take = hsel && htrans[1] && hready && hreadyout_q;
	assign wr_now = req_q.valid && req_q.write;
	assign rd_now = req_q.valid && !req_q.write;

	// Bus and pin outputs
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign ta_out = ta_out_q;
	assign ta_oe_n = ta_oe_n_q;
	assign tmr_ic_pins = ic_pins_q;
	assign tmr_pai = pai_q;
	assign tmr_count = count_q;
	assign pb_out = pb_out_q;
	assign pc_out = pc_out_q;
	assign pc_oe_n = pc_oe_n_q;
	assign pc_pullup_en = pullup_q;
	assign ext_bus_rdata = bus_rdata_q;

	// Address phase capture; reads add one wait state so a preceding write is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= REQ_RESET;
			hreadyout_q <= 1'b1;
		end else begin
			if (take) begin
				req_q <= '{valid: 1'b1, write: hwrite, idx: haddr[15:2]};
				hreadyout_q <= hwrite;
			end else begin
				req_q <= REQ_RESET;
				hreadyout_q <= 1'b1;
			end
		end
	end

	// Response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// Read mux; unmapped or removed registers read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (req_q.idx)
			IDX_TIMER_DATA: begin
				rd_mux[7:0] = (ta_dir_q & ta_latch_q) | (~ta_dir_q & ta_in);
			end
			IDX_TIMER_DIR: begin
				rd_mux[7:0] = ta_dir_q;
			end
			IDX_UPPER_DATA: begin
				rd_mux[7:0] = single_chip ? pb_latch_q : 8'h00;
			end
			IDX_DBUS_DATA: begin
				if (single_chip) begin
					rd_mux[7:0] = (pc_dir_q & pc_latch_q) | (~pc_dir_q & pc_in);
				end
			end
			IDX_DBUS_DIR: begin
				rd_mux[7:0] = pc_dir_q;
			end
			IDX_OPTIONS_TWO: begin
				rd_mux[OPEN_DRAIN_BIT] = open_drain_q;
			end
			IDX_PULSE_CTRL: begin
				rd_mux[CAPTURE_SEL_BIT] = capture_sel_q;
			end
			IDX_SHARED_CC: begin
				rd_mux[15:0] = shared_cc_q;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Read data is registered during the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= RDATA_RESET;
		end else if (rd_now) begin
			hrdata_q <= rd_mux;
		end
	end

	// Direction registers clear on reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ta_dir_q <= DIR_RESET;
			pc_dir_q <= DIR_RESET;
		end else if (wr_now) begin
			if (req_q.idx == IDX_TIMER_DIR) begin
				ta_dir_q <= hwdata[7:0];
			end
			if (req_q.idx == IDX_DBUS_DIR) begin
				pc_dir_q <= hwdata[7:0];
			end
		end
	end

	// Floating-pin latches take the pin level on the first edge after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_q <= 1'b1;
			ta_latch_q <= 8'h00;
			pc_latch_q <= 8'h00;
		end else begin
			init_q <= 1'b0;
			if (init_q) begin
				ta_latch_q <= ta_in;
				pc_latch_q <= pc_in;
			end else if (wr_now) begin
				if (req_q.idx == IDX_TIMER_DATA) begin
					ta_latch_q <= hwdata[7:0];
				end
				if (req_q.idx == IDX_DBUS_DATA && single_chip) begin
					pc_latch_q <= hwdata[7:0];
				end
			end
		end
	end

	// Upper port latch is written only while it is in the map
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pb_latch_q <= UPPER_RESET;
		end else if (wr_now && req_q.idx == IDX_UPPER_DATA && single_chip) begin
			pb_latch_q <= hwdata[7:0];
		end
	end

	// Options and capture select
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_drain_q <= OPTIONS_RESET[OPEN_DRAIN_BIT];
			capture_sel_q <= 1'b0;
		end else if (wr_now) begin
			if (req_q.idx == IDX_OPTIONS_TWO) begin
				open_drain_q <= hwdata[OPEN_DRAIN_BIT];
			end
			if (req_q.idx == IDX_PULSE_CTRL) begin
				capture_sel_q <= hwdata[CAPTURE_SEL_BIT];
			end
		end
	end

	// Free-running count used as the capture time base
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= COUNT_RESET;
		end else begin
			count_q <= count_q + 16'h0001;
		end
	end

	// Pin 3 rising edges capture whether driven from outside or by the port latch
	assign cap_evt = capture_sel_q && ta_in[PIN_CAPTURE] && !pin3_prev_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin3_prev_q <= 1'b0;
			shared_cc_q <= SHARED_RESET;
		end else begin
			pin3_prev_q <= ta_in[PIN_CAPTURE];
			if (cap_evt) begin
				shared_cc_q <= count_q;
			end else if (wr_now && req_q.idx == IDX_SHARED_CC && !capture_sel_q) begin
				shared_cc_q <= hwdata[15:0];
			end
		end
	end

	// Compare outputs take a pin; fifth compare is off while pin 3 captures
	// Levels are widened to the full port so low pins never index past the compare range
	always_comb begin
		oc_drive = 8'h00;
		oc_level = 8'h00;
		oc_drive[7:3] = tmr_oc_en;
		oc_level[7:3] = tmr_oc_val;
		if (capture_sel_q) begin
			oc_drive[PIN_CAPTURE] = 1'b0;
		end
	end

	// Timer port pin drivers and feeds to the timer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ta_out_q <= 8'h00;
			ta_oe_n_q <= 8'hff;
			ic_pins_q <= 4'h0;
			pai_q <= 1'b0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				ta_oe_n_q[i] <= !(ta_dir_q[i] || oc_drive[i]);
				if (oc_drive[i]) begin
					ta_out_q[i] <= oc_level[i];
				end else begin
					ta_out_q[i] <= ta_latch_q[i];
				end
			end
			ic_pins_q <= {ta_in[PIN_CAPTURE] && capture_sel_q, ta_in[0], ta_in[1], ta_in[2]};
			pai_q <= ta_in[PIN_ACCUM];
		end
	end

	// Upper address port: latch or address, by mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pb_out_q <= UPPER_RESET;
		end else begin
			pb_out_q <= single_chip ? pb_latch_q : ext_addr_hi;
		end
	end

	// Data-bus port drivers; open drain only honoured in single-chip modes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_out_q <= 8'h00;
			pc_oe_n_q <= 8'hff;
			pullup_q <= 1'b1;
			bus_rdata_q <= 8'h00;
		end else begin
			bus_rdata_q <= pc_in;
			if (!single_chip) begin
				pc_out_q <= ext_bus_wdata;
				pc_oe_n_q <= {8{ext_bus_rnw}};
				pullup_q <= 1'b1;
			end else if (open_drain_q) begin
				pc_out_q <= 8'h00;
				pc_oe_n_q <= ~(pc_dir_q & ~pc_latch_q);
				pullup_q <= 1'b0;
			end else begin
				pc_out_q <= pc_latch_q;
				pc_oe_n_q <= ~pc_dir_q;
				pullup_q <= 1'b1;
			end
		end
	end

	// Checks on the behaviour above
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite) |=> !hreadyout_q ##1 hreadyout_q)
		else $error("read did not take exactly one wait state");
	a_dir_pins_low: assert property (@(posedge hclk) disable iff (!hresetn)
		ta_oe_n_q[2:0] == ~$past(ta_dir_q[2:0]))
		else $error("timer low pins do not follow direction");
	a_accum_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> pai_q == $past(ta_in[PIN_ACCUM]))
		else $error("accumulator input does not follow pin 7");
	a_capture_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && req_q.idx == IDX_SHARED_CC && capture_sel_q && !cap_evt)
		|=> $stable(shared_cc_q))
		else $error("shared register changed by a write while capturing");
	a_capture_take: assert property (@(posedge hclk) disable iff (!hresetn)
		cap_evt |=> shared_cc_q == $past(count_q))
		else $error("pin 3 edge did not capture the count");
	a_oc5_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(capture_sel_q && !ta_dir_q[PIN_CAPTURE]) |=> ta_oe_n_q[PIN_CAPTURE])
		else $error("fifth compare drove pin 3 during capture");
	a_upper_addr: assert property (@(posedge hclk) disable iff (!hresetn)
		!single_chip |=> pb_out_q == $past(ext_addr_hi))
		else $error("upper port does not carry address in expanded mode");
	a_drain_high: assert property (@(posedge hclk) disable iff (!hresetn)
		(single_chip && open_drain_q && pc_latch_q[0]) |=> pc_oe_n_q[0] && !pullup_q)
		else $error("open-drain one was driven");
	a_drain_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
		!single_chip |=> pullup_q && (pc_oe_n_q == {8{$past(ext_bus_rnw)}}))
		else $error("open drain acted outside single-chip modes");
	a_upper_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_now && req_q.idx == IDX_UPPER_DATA && !single_chip) |=> hrdata_q == 32'h0000_0000)
		else $error("upper port register readable in expanded mode");
endmodule

// >>> verification/ppab_pin_model.sv
`timescale 1ns/100ps
module ppab_pin_model (
	// Clock
	input wire logic hclk,
	// Device side of the pins
	input wire logic [7:0] ta_out,
	input wire logic [7:0] ta_oe_n,
	input wire logic [7:0] pc_out,
	input wire logic [7:0] pc_oe_n,
	input wire logic pc_pullup_en,
	// Outside drivers set by the bench
	input wire logic [7:0] ta_ext,
	input wire logic [7:0] ta_ext_en,
	input wire logic [7:0] pc_ext,
	input wire logic [7:0] pc_ext_en,
	// Resolved pin levels
	output logic [7:0] ta_in,
	output logic [7:0] pc_in
);
	logic [7:0] float_q = 8'h5a;

	// Unpulled timer lines wander, so a stale level never passes for a drive
	always @(posedge hclk) begin
		float_q <= ~float_q;
	end

	// Device drive wins, then the outside driver, else the resting level
	// Board pull-up keeps released data-bus lines high, internal pull-up or not
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			ta_in[b] = !ta_oe_n[b] ? ta_out[b] : ta_ext_en[b] ? ta_ext[b] : float_q[b];
			pc_in[b] = !pc_oe_n[b] ? pc_out[b] : pc_ext_en[b] ? pc_ext[b] : 1'b1;
		end
	end
endmodule

// >>> verification/parallel_port_abc_logic_tb.sv
`timescale 1ns/100ps
module parallel_port_abc_logic_tb;
	import ppab_pkg::*;
	logic hclk, hresetn, hsel, hwrite, ext_bus_rnw, hreadyout, hresp, tmr_pai, pc_pullup_en;
	logic rd_ph;
	logic [1:0] htrans, op_mode;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, lf, eq[$], aq[$];
	logic [7:0] ta_in, ta_out, ta_oe_n, ext_addr_hi, pb_out, pc_in, pc_out, pc_oe_n;
	logic [7:0] ext_bus_wdata, ext_bus_rdata, ta_ext, ta_ext_en, pc_ext, pc_ext_en, v, w;
	logic [7:3] tmr_oc_en, tmr_oc_val;
	logic [3:0] tmr_ic_pins;
	logic [15:0] tmr_count;
	logic [15:0] cnt;
	int n_mismatch, checks;

	ppab_port_logic i_ppab_port_logic (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.op_mode(op_mode), .ta_in(ta_in), .ta_out(ta_out), .ta_oe_n(ta_oe_n),
		.tmr_oc_en(tmr_oc_en), .tmr_oc_val(tmr_oc_val), .tmr_ic_pins(tmr_ic_pins),
		.tmr_pai(tmr_pai), .tmr_count(tmr_count), .ext_addr_hi(ext_addr_hi), .pb_out(pb_out),
		.pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pc_pullup_en(pc_pullup_en),
		.ext_bus_rnw(ext_bus_rnw), .ext_bus_wdata(ext_bus_wdata), .ext_bus_rdata(ext_bus_rdata));

	ppab_pin_model i_ppab_pin_model (.hclk(hclk), .ta_out(ta_out), .ta_oe_n(ta_oe_n),
		.pc_out(pc_out), .pc_oe_n(pc_oe_n), .pc_pullup_en(pc_pullup_en), .ta_ext(ta_ext),
		.ta_ext_en(ta_ext_en), .pc_ext(pc_ext), .pc_ext_en(pc_ext_en), .ta_in(ta_in),
		.pc_in(pc_in));

	// Clock, 50 ns period
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	function automatic logic [7:0] rnd();
		repeat (8) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	// One single transfer; the read expectation is queued for the monitor
	task automatic bus(input logic wr_en, input logic [13:0] i, input logic [31:0] d, e);
		haddr <= {16'h0000, i, 2'b00};
		hwrite <= wr_en;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		if (!wr_en) begin
			eq.push_back(e);
			aq.push_back({16'h0000, i, 2'b00});
		end
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [13:0] i, input logic [15:0] d);
		bus(1'b1, i, {16'h0000, d}, '0);
	endtask

	task automatic rd(input logic [13:0] i, input logic [15:0] e);
		bus(1'b0, i, '0, {16'h0000, e});
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Read data is taken at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			chk($sformatf("hrdata at %h", aq.pop_front()), eq.pop_front(), hrdata);
			rd_ph = 1'b0;
		end
		if (htrans[1] && !hwrite && hreadyout === 1'b1) begin
			rd_ph = 1'b1;
		end
	end

	// Watchdog, far beyond the 140 or so cycles the tests need
	initial begin
		#500000;
		n_mismatch++;
		conclude();
	end

	initial begin
		rd_ph = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'b010;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = '0;
		op_mode = MODE_SINGLE;
		tmr_oc_en = '0;
		tmr_oc_val = '0;
		ext_addr_hi = '0;
		ext_bus_rnw = 1'b1;
		ext_bus_wdata = '0;
		ta_ext = 8'h3c;
		ta_ext_en = 8'hff;
		pc_ext = '0;
		pc_ext_en = '0;
		lf = 32'h8b838747;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		tick(1);
		chk("ta_oe_n", 8'hff, ta_oe_n);
		chk("pc_oe_n", 8'hff, pc_oe_n);
		chk("pb_out", UPPER_RESET, pb_out);
		chk("hresp", 1'b0, hresp);
		// Capture time base must advance by one on every clock
		cnt = tmr_count;
		tick(10);
		chk("tmr_count", 16'(cnt + 16'h000a), tmr_count);
		rd(IDX_TIMER_DIR, DIR_RESET);
		rd(IDX_UPPER_DATA, UPPER_RESET);
		rd(IDX_OPTIONS_TWO, OPTIONS_RESET);
		rd(IDX_TIMER_DATA, 16'h003c);
		// Turning the pins around shows the latch that took the reset-time level
		wr(IDX_TIMER_DIR, 16'h00ff);
		rd(IDX_TIMER_DATA, 16'h003c);
		chk("ta_out", 8'h3c, ta_out);
		rd(14'h1200, 16'h0000);
		$display("test reset done");
		// Random direction and latch mixes on the timer port
		for (int k = 0; k < 4; k++) begin
			v = rnd();
			v[7] = k[0];
			w = rnd();
			ta_ext <= rnd();
			wr(IDX_TIMER_DIR, v);
			wr(IDX_TIMER_DATA, w);
			tick(3);
			chk("ta_oe_n", {24'h0, ~v}, ta_oe_n);
			chk("ta_out", w & v, ta_out & v);
			chk("tmr_pai", ta_in[7], tmr_pai);
			chk("tmr_ic_pins", {1'b0, ta_in[0], ta_in[1], ta_in[2]}, tmr_ic_pins);
			rd(IDX_TIMER_DATA, (v & w) | (~v & ta_ext));
		end
		$display("test timer port done");
		v = rnd();
		wr(IDX_UPPER_DATA, v);
		tick(3);
		chk("pb_out", v, pb_out);
		op_mode <= MODE_EXPANDED;
		ext_addr_hi <= rnd();
		tick(3);
		chk("pb_out", ext_addr_hi, pb_out);
		rd(IDX_UPPER_DATA, 16'h0000);
		rd(IDX_DBUS_DATA, 16'h0000);
		// Open drain asked for while expanded must not take effect
		wr(IDX_OPTIONS_TWO, 16'h0040);
		ext_bus_rnw <= 1'b0;
		ext_bus_wdata <= rnd();
		tick(3);
		chk("pc_oe_n", 8'h00, pc_oe_n);
		chk("pc_out", ext_bus_wdata, pc_out);
		chk("pc_pullup_en", 1'b1, pc_pullup_en);
		ext_bus_rnw <= 1'b1;
		pc_ext_en <= 8'hff;
		pc_ext <= rnd();
		tick(3);
		chk("pc_oe_n", 8'hff, pc_oe_n);
		chk("ext_bus_rdata", pc_ext, ext_bus_rdata);
		$display("test expanded mode done");
		op_mode <= MODE_BOOT;
		pc_ext_en <= 8'h00;
		v = rnd();
		v[0] = 1'b1;
		wr(IDX_DBUS_DIR, 16'h00ff);
		wr(IDX_DBUS_DATA, v);
		tick(3);
		chk("pc_pullup_en", 1'b0, pc_pullup_en);
		chk("pc_oe_n", v, pc_oe_n);
		rd(IDX_OPTIONS_TWO, 16'h0040);
		rd(IDX_DBUS_DATA, v);
		wr(IDX_OPTIONS_TWO, 16'h0000);
		tick(3);
		chk("pc_oe_n", 8'h00, pc_oe_n);
		chk("pc_out", v, pc_out);
		$display("test open drain done");
		tmr_oc_en <= 5'h01;
		tmr_oc_val <= 5'h01;
		tick(3);
		chk("ta_out3", 1'b1, ta_out[3]);
		chk("capture4", 1'b0, tmr_ic_pins[3]);
		tmr_oc_en <= 5'h00;
		wr(IDX_TIMER_DIR, 16'h0008);
		wr(IDX_TIMER_DATA, 16'h0000);
		wr(IDX_PULSE_CTRL, 16'h0004);
		wr(IDX_SHARED_CC, 16'h1234);
		rd(IDX_SHARED_CC, SHARED_RESET);
		wr(IDX_TIMER_DATA, 16'h0008);
		tick(3);
		chk("capture4", 1'b1, tmr_ic_pins[3]);
		// Pin 3 as capture input keeps the fifth compare off it; pin 7 compare still feeds the accumulator
		wr(IDX_TIMER_DIR, 16'h0000);
		tmr_oc_en <= 5'h11;
		tmr_oc_val <= 5'h11;
		tick(3);
		chk("ta_oe_n", 8'h7f, ta_oe_n);
		chk("tmr_pai", 1'b1, tmr_pai);
		$display("test capture done");
		tick(2);
		chk("pending reads", 0, eq.size());
		conclude();
	end
endmodule
